/* File: bench/hsq_link_sva.sv */
// assertions on the sensor link wires and the measurement sequencer
`timescale 1ns/1ps
module hsq_link_sva
    import hsq_pkg::*;
#(
    parameter int STARTUP_CYC = HSQ_STARTUP_CYC,
    parameter int PERIOD_CYC  = HSQ_PERIOD_CYC
) (
    // device clock and reset
    input wire logic osc_clk,
    input wire logic por_rst,
    // link wires
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    // device status
    input wire logic data_ready,
    input wire logic conv_busy
);
    localparam int BUSY_CYC = HSQ_CAP_CONV_CYC + HSQ_RES_CONV_CYC + 1;
    logic       scl_q, sda_q, busy_q, act_r, rd_r, nak_r, seen_r;
    logic [3:0] bit_r, byte_r;
    logic [7:0] sh_r;
    int         bc_r, per_r, up_r;
    logic       rise, start, stop, brise;

    // edge and condition decode on the raw wires and on conv_busy
    assign rise  = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;
    assign stop  = scl && scl_q && !sda_q && sda;
    assign brise = conv_busy && !busy_q;

    // bit, byte and direction tracking plus sequencer counters
    always_ff @(posedge osc_clk) begin
        scl_q  <= scl;
        sda_q  <= sda;
        busy_q <= conv_busy;
        bc_r   <= conv_busy ? bc_r + 1 : 0;
        per_r  <= brise ? 1 : per_r + 1;
        up_r   <= up_r + 1;
        if (brise) begin
            seen_r <= 1'b1;
        end
        if (start) begin
            act_r  <= 1'b1;
            rd_r   <= 1'b0;
            nak_r  <= 1'b0;
            bit_r  <= 4'h0;
            byte_r <= 4'h0;
        end else if (stop) begin
            act_r <= 1'b0;
        end else if (rise && bit_r == 4'h8) begin
            bit_r  <= 4'h0;
            byte_r <= byte_r + 4'h1;
            if (byte_r == 4'h0) rd_r <= sh_r[0];
            if (rd_r && byte_r != 4'h0 && sda) nak_r <= 1'b1;
        end else if (rise) begin
            bit_r <= bit_r + 4'h1;
            sh_r  <= {sh_r[6:0], sda};
        end
        if (por_rst) begin
            act_r  <= 1'b0;
            seen_r <= 1'b0;
            nak_r  <= 1'b0;
            up_r   <= 0;
        end
    end

    default clocking cb @(posedge osc_clk); endclocking
    default disable iff (por_rst);

    // a read bit stays put for four device clocks after the clock rises
    sequence s_bit_held;
        $stable(sda) [*4];
    endsequence

    a_addr_ack: assert property (
        rise && act_r && byte_r == 4'h0 && bit_r == 4'h8 && sh_r[7:1] == HSQ_SLAVE_ADDR
        |-> dev_sda_oe && !sda) else $error("own address not acknowledged");
    a_wr_ack: assert property (
        rise && act_r && !rd_r && byte_r != 4'h0 && bit_r == 4'h8
        |-> dev_sda_oe) else $error("written byte not acknowledged");
    a_wr_quiet: assert property (
        rise && act_r && (byte_r == 4'h0 || !rd_r) && bit_r != 4'h8
        |-> !dev_sda_oe) else $error("device drives a bit of the master");
    a_rd_bit: assert property (
        rise && act_r && rd_r && !nak_r && byte_r != 4'h0 && bit_r != 4'h8
        |-> (dev_sda_oe != sda) ##1 s_bit_held) else $error("read bit not held");
    a_rd_release: assert property (
        rise && act_r && rd_r && byte_r != 4'h0 && bit_r == 4'h8
        |-> !dev_sda_oe) else $error("device drives master acknowledge");
    a_nak_quiet: assert property (
        nak_r |-> !dev_sda_oe) else $error("device drives after not-acknowledge");
    a_stop_idle: assert property (
        stop |=> (!dev_sda_oe) [*8]) else $error("bus held after stop");
    a_busy_len: assert property (
        $fell(conv_busy) |-> bc_r == BUSY_CYC) else $error("conversion length wrong");
    a_ready_proc: assert property (
        $rose(data_ready) |-> $past(conv_busy) && !conv_busy) else $error("ready early");
    a_cycle_period: assert property (
        brise && seen_r |-> per_r == PERIOD_CYC) else $error("measurement period wrong");
    a_startup_wait: assert property (
        brise && !seen_r |-> up_r >= STARTUP_CYC - 1 && up_r <= STARTUP_CYC + 2)
        else $error("first conversion at wrong time");
endmodule

/* File: bench/testbench.sv */
// self-checking bench: bus master and sensor device joined on one link
`timescale 1ns/1ps
module testbench;
    import hsq_pkg::*;
    localparam int          STARTUP = 100;
    localparam int          PERIOD  = 400;
    localparam int          LIMIT   = 32'h0001_3880;
    localparam logic [15:0] CAP     = 16'h5C3E;
    localparam logic [15:0] RES     = 16'h9A87;
    logic        clk, sys_rst, osc_clk, por_rst, cmd_valid, cmd_read;
    logic        cmd_ready, rd_valid, done, nack_err, data_ready, conv_busy;
    logic [3:0]  cmd_len;
    logic [63:0] cmd_wdata;
    logic [7:0]  rd_data;
    logic [7:0]  got[$];
    int          bad_count = 0;
    int          comparisons = 0;
    int          cyc = 0;

    hsq_link_if link_if ();

    hsq_host hsq_host_inst (.clk(clk), .sys_rst(sys_rst), .link(link_if.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .nack_err(nack_err));

    hsq_dev #(.STARTUP_CYC(STARTUP), .PERIOD_CYC(PERIOD)) hsq_dev_inst (
        .osc_clk(osc_clk), .por_rst(por_rst), .link(link_if.dev), .cap_code(CAP),
        .res_code(RES), .data_ready(data_ready), .conv_busy(conv_busy));

    hsq_link_sva #(.STARTUP_CYC(STARTUP), .PERIOD_CYC(PERIOD)) hsq_link_sva_inst (
        .osc_clk(osc_clk), .por_rst(por_rst), .scl(link_if.scl), .sda(link_if.sda),
        .dev_sda_oe(link_if.dev_sda_oe), .data_ready(data_ready), .conv_busy(conv_busy));

    // system clock and an unrelated device clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        osc_clk = 1'b0;
        #3;
        forever #16 osc_clk = ~osc_clk;
    end

    task automatic wrap_up();
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one host transaction; read bytes are gathered until done
    task automatic xfer(input logic rd, input logic [3:0] len, input logic [63:0] wd);
        while (cmd_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        cmd_valid = 1'b1;
        cmd_read  = rd;
        cmd_len   = len;
        cmd_wdata = wd;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        got.delete();
        while (done !== 1'b1) begin
            @(posedge clk);
            #1;
            if (rd_valid === 1'b1) got.push_back(rd_data);
        end
        chk("nack_err", 16'h0000, {15'h0000, nack_err});
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        sys_rst   = 1'b1;
        por_rst   = 1'b1;
        cmd_valid = 1'b0;
        cmd_read  = 1'b0;
        cmd_len   = 4'h0;
        cmd_wdata = 64'h0000_0000_0000_0000;
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        por_rst = 1'b0;
        repeat (100) @(posedge clk);
        #1;
        chk("ready_early", 16'h0000, {15'h0000, data_ready});
        chk("bus_idle", 16'h0003, {14'h0000, link_if.scl, link_if.sda});
        // wait for data_ready so the first command finds a measurement in the store
        while (data_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        // point at the temperature checksum, then read across into humidity
        xfer(1'b0, 4'h2, {8'h40, 8'h02, 48'h0000_0000_0000});
        xfer(1'b1, 4'h3, 64'h0000_0000_0000_0000);
        chk("count", 16'h0003, 16'(got.size()));
        chk("byte0", {8'h00, RES[15:8] + RES[7:0]}, {8'h00, got[0]});
        chk("byte1", {8'h00, CAP[15:8]}, {8'h00, got[1]});
        chk("byte2", {8'h00, CAP[7:0]}, {8'h00, got[2]});
        chk("released", 16'h0000, {15'h0000, link_if.dev_sda_oe});
        chk("bus_free", 16'h0003, {14'h0000, link_if.scl, link_if.sda});
        wrap_up();
    end
endmodule

/* File: verilog/hsq_dev.sv */
// sensor device: serial slave port and timed measurement sequencer
`timescale 1ns/1ps
module hsq_dev
    import hsq_pkg::*;
#(
    parameter int STARTUP_CYC = HSQ_STARTUP_CYC,
    parameter int PERIOD_CYC  = HSQ_PERIOD_CYC
) (
    // oscillator clock and power-on reset
    input  wire logic        osc_clk,
    input  wire logic        por_rst,
    // link side
    hsq_link_if.dev          link,
    // analog front end codes
    input  wire logic [15:0] cap_code,
    input  wire logic [15:0] res_code,
    // status
    output logic             data_ready,
    output logic             conv_busy
);
    localparam int SW = $clog2(STARTUP_CYC + 1);
    localparam int TW = $clog2(PERIOD_CYC + 1);

    typedef struct packed {
        logic            sc1;
        logic            sc2;
        logic            sc3;
        logic            sd1;
        logic            sd2;
        logic            sd3;
        hsq_dstate_t     st;
        logic [2:0]      cnt;
        logic            first;
        logic            rd;
        logic            phase;
        logic [1:0]      wcnt;
        logic [7:0]      opc;
        logic [2:0]      ptr;
        logic [7:0]      sh;
        logic            oe;
        hsq_mstate_t     mst;
        logic [SW-1:0]   su;
        logic [TW-1:0]   tmr;
        logic [4:0]      mcnt;
        logic            ready;
        logic [15:0]     cap;
        logic [15:0]     res;
        logic [7:0][7:0] store;
    } hsq_dev_t;

    hsq_dev_t s_r;
    hsq_dev_t s_nxt;

    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       trig;
    logic [7:0] rx_byte;

    // bus events from the synchronised copies only
    assign rise    = s_r.sc2 & ~s_r.sc3;
    assign fall    = ~s_r.sc2 & s_r.sc3;
    assign start   = s_r.sc2 & s_r.sc3 & ~s_r.sd2 & s_r.sd3;
    assign stop    = s_r.sc2 & s_r.sc3 & s_r.sd2 & ~s_r.sd3;
    assign rx_byte = {s_r.sh[6:0], s_r.sd2};
    assign trig    = (s_r.tmr == TW'(PERIOD_CYC - 1));

    // next state of link engine and sequencer
    always_comb begin
        s_nxt     = s_r;
        s_nxt.sc1 = link.scl;
        s_nxt.sc2 = s_r.sc1;
        s_nxt.sc3 = s_r.sc2;
        s_nxt.sd1 = link.sda;
        s_nxt.sd2 = s_r.sd1;
        s_nxt.sd3 = s_r.sd2;

        // slave engine: never drives a start, only follows the master
        if (stop) begin
            s_nxt.st = D_IDLE;
            s_nxt.oe = 1'b0;
        end else if (start) begin
            s_nxt.st    = D_RX;
            s_nxt.cnt   = 3'h0;
            s_nxt.first = 1'b1;
            s_nxt.phase = 1'b0;
            s_nxt.wcnt  = 2'h0;
            s_nxt.oe    = 1'b0;
        end else begin
            case (s_r.st)
                D_RX: begin
                    if (rise) begin
                        s_nxt.sh  = rx_byte;
                        s_nxt.cnt = s_r.cnt + 3'h1;
                        if (s_r.cnt == 3'h7) begin
                            s_nxt.st = D_ACK;
                            if (s_r.first) begin
                                s_nxt.rd = rx_byte[0];
                                if (rx_byte[7:1] != HSQ_SLAVE_ADDR) begin
                                    s_nxt.st = D_IGN;
                                end
                            end else begin
                                // opcode, then register address, then payload
                                if (s_r.wcnt == 2'h0) begin
                                    s_nxt.opc = rx_byte;
                                end else if (s_r.wcnt == 2'h1) begin
                                    s_nxt.ptr = rx_byte[2:0];
                                end
                                if (s_r.wcnt != 2'h3) begin
                                    s_nxt.wcnt = s_r.wcnt + 2'h1;
                                end
                            end
                        end
                    end
                end
                D_ACK: begin
                    // drive low through the ninth clock only
                    if (fall && !s_r.phase) begin
                        s_nxt.oe    = 1'b1;
                        s_nxt.phase = 1'b1;
                    end else if (fall) begin
                        s_nxt.phase = 1'b0;
                        s_nxt.first = 1'b0;
                        s_nxt.cnt   = 3'h0;
                        if (s_r.rd) begin
                            s_nxt.st = D_TX;
                            s_nxt.sh = s_r.store[s_r.ptr];
                            s_nxt.oe = ~s_r.store[s_r.ptr][7];
                        end else begin
                            s_nxt.st = D_RX;
                            s_nxt.oe = 1'b0;
                        end
                    end
                end
                D_TX: begin
                    if (rise) begin
                        s_nxt.cnt = s_r.cnt + 3'h1;
                        if (s_r.cnt == 3'h7) begin
                            s_nxt.st = D_MACK;
                        end
                    end else if (fall) begin
                        s_nxt.sh = {s_r.sh[6:0], 1'b0};
                        s_nxt.oe = ~s_r.sh[6];
                    end
                end
                D_MACK: begin
                    if (fall && !s_r.phase) begin
                        s_nxt.oe    = 1'b0;
                        s_nxt.phase = 1'b1;
                    end else if (rise && s_r.phase) begin
                        if (s_r.sd2) begin
                            s_nxt.st    = D_IGN;
                            s_nxt.phase = 1'b0;
                        end else begin
                            s_nxt.ptr = s_r.ptr + 3'h1;
                        end
                    end else if (fall && s_r.phase) begin
                        s_nxt.phase = 1'b0;
                        s_nxt.cnt   = 3'h0;
                        s_nxt.st    = D_TX;
                        s_nxt.sh    = s_r.store[s_r.ptr];
                        s_nxt.oe    = ~s_r.store[s_r.ptr][7];
                    end
                end
                D_IGN: begin
                    s_nxt.oe = 1'b0;
                end
                D_IDLE: begin
                    s_nxt.oe = 1'b0;
                end
                default: begin
                    s_nxt.st = D_IDLE;
                    s_nxt.oe = 1'b0;
                end
            endcase
        end

        // conversion timer runs once start-up is over
        if (s_r.mst != M_START) begin
            s_nxt.tmr = trig ? '0 : s_r.tmr + TW'(1);
        end

        // measurement sequencer
        case (s_r.mst)
            M_START: begin
                s_nxt.su = s_r.su + SW'(1);
                if (s_r.su == SW'(STARTUP_CYC - 1)) begin
                    s_nxt.mst  = M_CAP;
                    s_nxt.mcnt = 5'h0;
                    s_nxt.tmr  = '0;
                end
            end
            M_WAIT: begin
                if (trig) begin
                    s_nxt.mst  = M_CAP;
                    s_nxt.mcnt = 5'h0;
                end
            end
            M_CAP: begin
                s_nxt.mcnt = s_r.mcnt + 5'h1;
                if (s_r.mcnt == 5'(HSQ_CAP_CONV_CYC - 1)) begin
                    s_nxt.cap  = cap_code;
                    s_nxt.mst  = M_RES;
                    s_nxt.mcnt = 5'h0;
                end
            end
            M_RES: begin
                s_nxt.mcnt = s_r.mcnt + 5'h1;
                if (s_r.mcnt == 5'(HSQ_RES_CONV_CYC - 1)) begin
                    s_nxt.res = res_code;
                    s_nxt.mst = M_PROC;
                end
            end
            M_PROC: begin
                // temperature from resistive, humidity from capacitive
                s_nxt.store[HSQ_IDX_TEMP]        = s_r.res[15:8];
                s_nxt.store[HSQ_IDX_TEMP + 3'h1] = s_r.res[7:0];
                s_nxt.store[HSQ_IDX_TEMP + 3'h2] = s_r.res[15:8] + s_r.res[7:0];
                s_nxt.store[HSQ_IDX_HUM]         = s_r.cap[15:8];
                s_nxt.store[HSQ_IDX_HUM + 3'h1]  = s_r.cap[7:0];
                s_nxt.store[HSQ_IDX_HUM + 3'h2]  = s_r.cap[15:8] + s_r.cap[7:0];
                s_nxt.ready = 1'b1;
                s_nxt.mst   = M_WAIT;
            end
            default: begin
                s_nxt.mst = M_WAIT;
            end
        endcase
        s_nxt.store[HSQ_IDX_STATUS] = {6'h00, s_nxt.ready, s_nxt.mst != M_WAIT};
    end

    // single state register
    always_ff @(posedge osc_clk) begin
        if (por_rst) begin
            s_r       <= '0;
            s_r.sc1   <= 1'b1;
            s_r.sc2   <= 1'b1;
            s_r.sc3   <= 1'b1;
            s_r.sd1   <= 1'b1;
            s_r.sd2   <= 1'b1;
            s_r.sd3   <= 1'b1;
            s_r.st    <= D_IDLE;
            s_r.mst   <= M_START;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = s_r.oe;
    assign data_ready      = s_r.ready;
    assign conv_busy       = (s_r.mst == M_CAP) || (s_r.mst == M_RES) || (s_r.mst == M_PROC);
endmodule

/* File: verilog/hsq_host.sv */
// bus master: runs one start-address-data-stop transaction per command
`timescale 1ns/1ps
module hsq_host
    import hsq_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // link side
    hsq_link_if.host         link,
    // command
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic [3:0]  cmd_len,
    input  wire logic [63:0] cmd_wdata,
    // results
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             done,
    output logic             nack_err
);
    typedef struct packed {
        logic        sd1;
        logic        sd2;
        hsq_hstate_t st;
        logic [8:0]  qcnt;
        logic [1:0]  q;
        logic [3:0]  bitn;
        logic [3:0]  idx;
        logic [3:0]  len;
        logic        rd;
        logic [7:0]  sh;
        logic [63:0] wbuf;
        logic        scl_oe;
        logic        sda_oe;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        done;
        logic        nack;
    } hsq_host_t;

    hsq_host_t s_r;
    hsq_host_t s_nxt;
    logic      tick;
    logic      tx;
    logic      last;

    assign tick = (s_r.qcnt == 9'(HSQ_QTR_CYC - 1));
    assign tx   = (s_r.idx == 4'h0) || !s_r.rd;
    assign last = (s_r.idx == s_r.len);

    // quarter-bit sequencer
    always_comb begin
        s_nxt        = s_r;
        s_nxt.sd1    = link.sda;
        s_nxt.sd2    = s_r.sd1;
        s_nxt.rvalid = 1'b0;
        s_nxt.done   = 1'b0;
        if (s_r.st != H_IDLE) begin
            s_nxt.qcnt = tick ? 9'h000 : s_r.qcnt + 9'h001;
            if (tick) begin
                s_nxt.q = s_r.q + 2'h1;
            end
        end
        case (s_r.st)
            H_IDLE: begin
                if (cmd_valid) begin
                    s_nxt.st   = H_START;
                    s_nxt.rd   = cmd_read;
                    s_nxt.len  = cmd_len;
                    s_nxt.wbuf = cmd_wdata;
                    s_nxt.nack = 1'b0;
                    s_nxt.qcnt = 9'h000;
                    s_nxt.q    = 2'h0;
                end
            end
            H_START: begin
                if (tick && s_r.q == 2'h1) begin
                    s_nxt.sda_oe = 1'b1;
                end else if (tick && s_r.q == 2'h3) begin
                    s_nxt.scl_oe = 1'b1;
                    s_nxt.st     = H_BIT;
                    s_nxt.bitn   = 4'h0;
                    s_nxt.idx    = 4'h0;
                    s_nxt.sh     = {HSQ_SLAVE_ADDR, s_r.rd};
                end
            end
            H_BIT: begin
                if (tick && s_r.q == 2'h0) begin
                    // data changes only while the clock is low
                    if (s_r.bitn != 4'h8) begin
                        s_nxt.sda_oe = tx & ~s_r.sh[7];
                    end else begin
                        s_nxt.sda_oe = !tx && !last;
                    end
                end else if (tick && s_r.q == 2'h1) begin
                    s_nxt.scl_oe = 1'b0;
                end else if (tick && s_r.q == 2'h3) begin
                    s_nxt.scl_oe = 1'b1;
                    s_nxt.bitn   = s_r.bitn + 4'h1;
                    if (s_r.bitn != 4'h8) begin
                        s_nxt.sh = tx ? {s_r.sh[6:0], 1'b0} : {s_r.sh[6:0], s_r.sd2};
                    end else if (tx && s_r.sd2) begin
                        s_nxt.nack = 1'b1;
                        s_nxt.st   = H_STOP;
                    end else begin
                        if (!tx) begin
                            s_nxt.rdata  = s_r.sh;
                            s_nxt.rvalid = 1'b1;
                        end
                        if (last) begin
                            s_nxt.st = H_STOP;
                        end else begin
                            s_nxt.idx  = s_r.idx + 4'h1;
                            s_nxt.bitn = 4'h0;
                            s_nxt.sh   = s_r.rd ? 8'h00 : s_r.wbuf[63:56];
                            s_nxt.wbuf = {s_r.wbuf[55:0], 8'h00};
                        end
                    end
                end
            end
            H_STOP: begin
                if (tick && s_r.q == 2'h0) begin
                    s_nxt.sda_oe = 1'b1;
                end else if (tick && s_r.q == 2'h1) begin
                    s_nxt.scl_oe = 1'b0;
                end else if (tick && s_r.q == 2'h3) begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.st     = H_IDLE;
                    s_nxt.done   = 1'b1;
                end
            end
            default: begin
                s_nxt.st = H_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r     <= '0;
            s_r.sd1 <= 1'b1;
            s_r.sd2 <= 1'b1;
            s_r.st  <= H_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign cmd_ready        = (s_r.st == H_IDLE);
    assign link.host_scl_o  = 1'b0;
    assign link.host_scl_oe = s_r.scl_oe;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = s_r.sda_oe;
    assign rd_data          = s_r.rdata;
    assign rd_valid         = s_r.rvalid;
    assign done             = s_r.done;
    assign nack_err         = s_r.nack;
endmodule

/* File: verilog/hsq_link_if.sv */
// two-wire link between the bus master and the sensor device
`timescale 1ns/1ps
interface hsq_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // open-drain wires with pull-up
    assign scl = host_scl_oe ? host_scl_o : 1'b1;
    assign sda = host_sda_oe ? host_sda_o : (dev_sda_oe ? dev_sda_o : 1'b1);

    modport host (
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        input  scl,
        input  sda
    );

    modport dev (
        output dev_sda_o,
        output dev_sda_oe,
        input  scl,
        input  sda
    );
endinterface

/* File: verilog/hsq_pkg.sv */
// shared constants and state types for the sensor serial link and sequencer
package hsq_pkg;
    localparam logic [6:0] HSQ_SLAVE_ADDR = 7'h28;
    localparam int         HSQ_MAX_WR     = 8;       // payload bytes per host command
    // device oscillator and sequencer timing
    localparam int HSQ_DEV_CLK_NS   = 32;
    localparam int HSQ_STARTUP_MS   = 10;
    localparam int HSQ_PERIOD_MS    = 200;
    localparam int HSQ_STARTUP_CYC  = HSQ_STARTUP_MS * 1000000 / HSQ_DEV_CLK_NS;
    localparam int HSQ_PERIOD_CYC   = HSQ_PERIOD_MS * 1000000 / HSQ_DEV_CLK_NS;
    localparam int HSQ_CAP_CONV_CYC = 16;
    localparam int HSQ_RES_CONV_CYC = 16;
    // host timing: one bit is four quarters
    localparam int HSQ_HOST_CLK_NS  = 10;
    localparam int HSQ_BIT_NS       = 10000;
    localparam int HSQ_QTR_CYC      = HSQ_BIT_NS / 4 / HSQ_HOST_CLK_NS;
    // result store byte indices
    localparam logic [2:0] HSQ_IDX_TEMP   = 3'h0;
    localparam logic [2:0] HSQ_IDX_HUM    = 3'h3;
    localparam logic [2:0] HSQ_IDX_STATUS = 3'h6;
    localparam logic [7:0] HSQ_OPC_RESET  = 8'h00;

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RX   = 3'b001,
        D_ACK  = 3'b010,
        D_TX   = 3'b011,
        D_MACK = 3'b100,
        D_IGN  = 3'b101
    } hsq_dstate_t;

    typedef enum logic [2:0] {
        M_START = 3'b000,
        M_WAIT  = 3'b001,
        M_CAP   = 3'b010,
        M_RES   = 3'b011,
        M_PROC  = 3'b100
    } hsq_mstate_t;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_START = 2'b01,
        H_BIT   = 2'b10,
        H_STOP  = 2'b11
    } hsq_hstate_t;
endpackage
